// [core/bms_pkg.sv]
// Constants, types and decode helpers of the buck mode sequencer
package bms_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int unsigned CLK_FREQ_MHZ     = 50;
    localparam int unsigned START_DELAY_US   = 100;
    // Whole microseconds times MHz is already an integer count
    localparam int unsigned START_DELAY_CYC  = START_DELAY_US * CLK_FREQ_MHZ;
    localparam logic [2:0]  PG_PULSES        = 3'h6;
    localparam logic [3:0]  DEM_ENTRY_PULSES = 4'h8;
    localparam logic [1:0]  PHASE_SAMPLE_CYC = 2'h2;

    // ----------------------------------------
    // Set-point in units of 10 uV
    // ----------------------------------------
    localparam logic [16:0] VSET_TOP      = 17'h1F6EE;
    localparam logic [16:0] VSET_STEP     = 17'h00A0F;
    localparam logic [16:0] VSET_FLOOR    = 17'h0A0F0;
    localparam logic [4:0]  VCODE_FLOOR   = 5'h1F;
    localparam int unsigned VCODE_SUSPEND = 4;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_SETPOINT = 12'h008;
    localparam logic [1:0]  CTRL_RESET    = 2'h1;
    localparam int unsigned CTRL_EN       = 0;
    localparam int unsigned CTRL_NODEM    = 1;
    localparam int unsigned STAT_STATE    = 0;
    localparam int unsigned STAT_SUPPLY   = 3;
    localparam int unsigned STAT_DEM      = 4;
    localparam int unsigned STAT_POWER_GOOD_OUTPUT    = 5;
    localparam int unsigned STAT_BOOST    = 6;
    localparam int unsigned STAT_AUDIO    = 7;
    localparam int unsigned STAT_W        = 8;

    // ----------------------------------------
    // Synchronised pin vector layout
    // ----------------------------------------
    localparam int unsigned PIN_EN    = 0;
    localparam int unsigned PIN_FDE   = 1;
    localparam int unsigned PIN_AF    = 2;
    localparam int unsigned PIN_PORR  = 3;
    localparam int unsigned PIN_PORF  = 4;
    localparam int unsigned PIN_PWM   = 5;
    localparam int unsigned PIN_PHASE = 6;
    localparam int unsigned PIN_INWIN = 7;
    localparam int unsigned PIN_SOV   = 8;
    localparam int unsigned PIN_SOVLO = 9;
    localparam int unsigned PIN_VC    = 10;
    localparam int unsigned PIN_W     = 15;

    typedef enum logic [2:0] {
        ST_OFF    = 3'b000,
        ST_DELAY  = 3'b001,
        ST_RAMP   = 3'b010,
        ST_PGWAIT = 3'b011,
        ST_RUN    = 3'b100,
        ST_FAULT  = 3'b101
    } bms_state_e;

    // Lowest code is full scale, top code jumps to the floor value
    function automatic logic [16:0] bms_setpoint(input logic [4:0] code);
        logic [21:0] drop;
        drop = 22'(code) * 22'(VSET_STEP);
        if (code == VCODE_FLOOR)
            return VSET_FLOOR;
        return VSET_TOP - drop[16:0];
    endfunction : bms_setpoint

endpackage : bms_pkg

// [core/bms_dem_if.sv]
// Link between the sequencer and the diode emulation tracker
interface bms_dem_if;
    logic allowed;
    logic sample;
    logic phasePos;
    logic active;

    modport seq (
        output allowed,
        output sample,
        output phasePos,
        input  active
    );

    modport tracker (
        input  allowed,
        input  sample,
        input  phasePos,
        output active
    );
endinterface : bms_dem_if

// [core/bms_dem_tracker.sv]
// Diode emulation entry and exit tracker
module bms_dem_tracker
    import bms_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Sequencer side
    bms_dem_if.tracker dem
);

    typedef struct packed {
        logic [3:0] posCount;
        logic       active;
    } bms_dem_s;

    bms_dem_s q;
    bms_dem_s d;

    always_comb
    begin
        d = q;
        if (!dem.allowed)
        begin
            d.posCount = 4'h0;
            d.active   = 1'b0;
        end
        else if (dem.sample)
        begin
            if (dem.phasePos)
            begin
                if (!q.active && q.posCount == DEM_ENTRY_PULSES - 4'h1)
                begin
                    d.active   = 1'b1;
                    d.posCount = 4'h0;
                end
                else if (!q.active)
                    d.posCount = q.posCount + 4'h1;
            end
            else
            begin
                d.posCount = 4'h0;
                d.active   = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            q <= '0;
        else
            q <= d;
    end

    assign dem.active = q.active;

endmodule : bms_dem_tracker

// [core/bms_mode_sequencer.sv]
// Buck regulator start-up, mode and protection sequencer with APB registers
module bms_mode_sequencer
    import bms_pkg::*;
#(
    parameter int unsigned START_DELAY_CYCLES = START_DELAY_CYC
)
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Supply comparators
    input  wire logic        supplyAboveRise,
    input  wire logic        supplyBelowFall,
    // System controller pins
    input  wire logic        converterEnablePin,
    input  wire logic [4:0]  voltageCodeInputs,
    input  wire logic        forcedDiodeEmulationSelect,
    input  wire logic        audioFilterEnable,
    // Modulator and analog sense
    input  wire logic        pwmRequest,
    input  wire logic        phaseNodePositive,
    input  wire logic        outputInWindow,
    input  wire logic        severeOvervoltage,
    input  wire logic        outputBelowRelease,
    // Power stage
    output logic             highSideGateDrive,
    output logic             lowSideGateDrive,
    // Open-drain power good
    output logic             powerGoodOut,
    output logic             powerGoodOe,
    // Analog control
    output logic             softStartRun,
    output logic [16:0]      setpointCode,
    output logic             windowBoost,
    output logic             audioFilterActive,
    output logic             diodeEmulationMode
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [PIN_W-1:0] pinMeta;
        logic [PIN_W-1:0] pinSync;
        logic             supplyOk;
        bms_state_e       state;
        logic [15:0]      delayCount;
        logic [2:0]       pgCount;
        logic             pwmPrev;
        logic             hsGate;
        logic             lsGate;
        logic [1:0]       lsAge;
        logic             lsBlock;
        logic             sovGate;
        logic             pgReleased;
        logic             softRun;
        logic [16:0]      setpoint;
        logic             boost;
        logic             audio;
        logic [1:0]       ctrl;
    } bms_seq_s;

    bms_seq_s q;
    bms_seq_s d;

    bms_dem_if dem ();

    logic [PIN_W-1:0] pinRaw;
    logic             pinEn;
    logic             pinPwm;
    logic             pinPhase;
    logic [4:0]       pinCode;
    logic             enabled;
    logic             hsRise;
    logic             suspendCode;
    logic             demAllowed;
    logic             forceCcm;
    logic             accessPhase;
    logic             mapped;
    logic [STAT_W-1:0] status;

    assign pinRaw = {voltageCodeInputs, outputBelowRelease, severeOvervoltage,
                     outputInWindow, phaseNodePositive, pwmRequest,
                     supplyBelowFall, supplyAboveRise, audioFilterEnable,
                     forcedDiodeEmulationSelect, converterEnablePin};

    // ----------------------------------------
    // Decoded conditions
    // ----------------------------------------
    assign pinEn    = q.pinSync[PIN_EN];
    assign pinPwm   = q.pinSync[PIN_PWM];
    assign pinPhase = q.pinSync[PIN_PHASE];
    assign pinCode  = q.pinSync[PIN_VC +: 5];

    assign enabled  = q.supplyOk && pinEn && q.ctrl[CTRL_EN];

    assign hsRise   = pinPwm && !q.pwmPrev;

    assign suspendCode = pinCode[VCODE_SUSPEND];

    assign forceCcm = (q.state != ST_RUN) || q.ctrl[CTRL_NODEM];

    assign demAllowed = !forceCcm
                        && (suspendCode || q.pinSync[PIN_FDE]);

    assign dem.allowed  = demAllowed;
    // Synchroniser lag: sampling earlier would see the node from before turn-on
    assign dem.sample   = q.lsGate && (q.lsAge == PHASE_SAMPLE_CYC);
    assign dem.phasePos = pinPhase;

    bms_dem_tracker u_tracker (
        .mclk (mclk),
        .srst (srst),
        .dem  (dem)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        d         = q;
        d.pinMeta = pinRaw;
        d.pinSync = q.pinMeta;
        d.pwmPrev = pinPwm;

        if (q.pinSync[PIN_PORR])
            d.supplyOk = 1'b1;
        else if (q.pinSync[PIN_PORF])
            d.supplyOk = 1'b0;

        d.setpoint = bms_setpoint(pinCode);

        case (q.state)
            ST_OFF:
            begin
                d.delayCount = 16'h0;
                if (enabled)
                    d.state = ST_DELAY;
            end
            ST_DELAY:
            begin
                if (q.delayCount == 16'(START_DELAY_CYCLES - 1))
                    d.state = ST_RAMP;
                else
                    d.delayCount = q.delayCount + 16'h1;
            end
            ST_RAMP:
            begin
                d.pgCount = 3'h0;
                if (q.pinSync[PIN_INWIN])
                    d.state = ST_PGWAIT;
            end
            ST_PGWAIT:
            begin
                if (hsRise && q.pgCount == PG_PULSES - 3'h1)
                    d.state = ST_RUN;
                else if (hsRise)
                    d.pgCount = q.pgCount + 3'h1;
            end
            ST_RUN:
            begin
                d.pgCount = 3'h0;
            end
            ST_FAULT:
            begin
                d.delayCount = 16'h0;
            end
            default:
            begin
                d.state = ST_OFF;
            end
        endcase

        if (q.state != ST_FAULT && !enabled)
            d.state = ST_OFF;

        if (q.supplyOk && q.pinSync[PIN_SOV])
            d.state = ST_FAULT;

        // Only a supply drop leaves the severe fault
        if (!q.supplyOk)
            d.state = ST_OFF;

        // Clamp low side while over, free it once the output has sagged
        if (q.pinSync[PIN_SOV])
            d.sovGate = 1'b1;
        else if (q.pinSync[PIN_SOVLO] || q.state != ST_FAULT)
            d.sovGate = 1'b0;

        // ----------------------------------------
        // Gate drive
        // ----------------------------------------
        if (!q.lsGate)
            d.lsAge = 2'h0;
        else if (q.lsAge != PHASE_SAMPLE_CYC + 2'h1)
            d.lsAge = q.lsAge + 2'h1;

        if (hsRise || !dem.active)
            d.lsBlock = 1'b0;
        else if (dem.sample && pinPhase)
            d.lsBlock = 1'b1;

        if (q.state == ST_RAMP || q.state == ST_PGWAIT || q.state == ST_RUN)
        begin
            d.hsGate = pinPwm;
            d.lsGate = !pinPwm && !(dem.active && d.lsBlock);
        end
        else if (q.state == ST_FAULT)
        begin
            d.hsGate = 1'b0;
            d.lsGate = d.sovGate;
        end
        else
        begin
            d.hsGate = 1'b0;
            d.lsGate = 1'b0;
        end

        d.softRun = (q.state == ST_RAMP || q.state == ST_PGWAIT
                     || q.state == ST_RUN);

        d.pgReleased = (d.state == ST_RUN);

        d.audio = q.pinSync[PIN_AF];

        d.boost = dem.active && !q.pinSync[PIN_AF];

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (accessPhase && pwrite && paddr == ADDR_CTRL)
            d.ctrl = pwdata[1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            q       <= '0;
            q.state <= ST_OFF;
            q.ctrl  <= CTRL_RESET;
        end
        else
            q <= d;
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // Zero wait states keep software polling cheap; reads are fixed muxes
    assign accessPhase = psel && penable;
    assign mapped      = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS)
                         || (paddr == ADDR_SETPOINT);
    assign pready      = 1'b1;
    assign pslverr     = accessPhase && !mapped;

    always_comb
    begin
        status                = '0;
        status[STAT_STATE +: 3] = q.state;
        status[STAT_SUPPLY]   = q.supplyOk;
        status[STAT_DEM]      = dem.active;
        status[STAT_POWER_GOOD_OUTPUT]    = q.pgReleased;
        status[STAT_BOOST]    = q.boost;
        status[STAT_AUDIO]    = q.audio;
        prdata                = 32'h0;
        if (accessPhase && !pwrite)
        begin
            case (paddr)
                ADDR_CTRL:     prdata = {30'h0, q.ctrl};
                ADDR_STATUS:   prdata = {24'h0, status};
                ADDR_SETPOINT: prdata = {15'h0, q.setpoint};
                default:       prdata = 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign highSideGateDrive  = q.hsGate;
    assign lowSideGateDrive   = q.lsGate;
    assign powerGoodOut       = 1'b0;
    assign powerGoodOe        = !q.pgReleased;
    assign softStartRun       = q.softRun;
    assign setpointCode       = q.setpoint;
    assign windowBoost        = q.boost;
    assign audioFilterActive  = q.audio;
    assign diodeEmulationMode = dem.active;

endmodule : bms_mode_sequencer

// [verification/bms_asserts.sv]
// Port-level assertion checker of the buck mode sequencer
module bms_asserts #(
    parameter int unsigned START_DELAY_CYCLES = 8
)
(
    // Clock and reset
    input wire logic        mclk,
    input wire logic        srst,
    // Pins and sense inputs
    input wire logic        supplyAboveRise,
    input wire logic        supplyBelowFall,
    input wire logic        converterEnablePin,
    input wire logic [4:0]  voltageCodeInputs,
    input wire logic        pwmRequest,
    input wire logic        severeOvervoltage,
    // Design outputs
    input wire logic        highSideGateDrive,
    input wire logic        lowSideGateDrive,
    input wire logic        powerGoodOe,
    input wire logic        softStartRun,
    input wire logic [16:0] setpointCode,
    input wire logic        windowBoost,
    input wire logic        audioFilterActive,
    input wire logic        diodeEmulationMode
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned enCnt_q;
    int unsigned pwCnt_q;
    logic        pwmPrev_q;

    function automatic logic [16:0] spv(input logic [4:0] c);
        return (c == 5'h1F) ? 17'h0A0F0 : 17'h1F6EE - 17'(c) * 17'h00A0F;
    endfunction : spv

    // ------
    // Helper counters
    // ------
    // Lower bounds only: the counts also run while other gates hold the start
    always_ff @(posedge mclk)
    begin
        pwmPrev_q <= pwmRequest;
        enCnt_q   <= (srst || !converterEnablePin) ? 0 : enCnt_q + 1;
        if (srst || !softStartRun)
            pwCnt_q <= 0;
        else if (powerGoodOe && pwmRequest && !pwmPrev_q)
            pwCnt_q <= pwCnt_q + 1;
    end

    // ------
    // Properties
    // ------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_gates_exclusive: assert property (highSideGateDrive |-> !lowSideGateDrive)
        else $error("both gate drives high");
    a_pg_held_low: assert property (!softStartRun && !$past(softStartRun) |-> powerGoodOe)
        else $error("power good released outside run");
    a_dem_after_start: assert property ($rose(diodeEmulationMode) |-> softStartRun && !powerGoodOe)
        else $error("emulation entered during start");
    a_boost_on: assert property ((diodeEmulationMode && !audioFilterActive)[*2] |-> windowBoost)
        else $error("window boost missing in emulation");
    a_boost_off: assert property (((!diodeEmulationMode)[*2] or audioFilterActive)
                                  |-> !windowBoost)
        else $error("window boost not suppressed");
    a_start_delay: assert property ($rose(softStartRun) |-> enCnt_q >= START_DELAY_CYCLES)
        else $error("ramp began before start delay");
    a_pg_pulse_count: assert property ($fell(powerGoodOe) |-> pwCnt_q >= 6)
        else $error("power good released too early");
    a_ov_shutdown: assert property (severeOvervoltage[*6] |-> !highSideGateDrive && powerGoodOe)
        else $error("no shutdown on severe overvoltage");
    a_enable_off: assert property ((!converterEnablePin)[*6] |-> !softStartRun && powerGoodOe)
        else $error("still running with enable low");
    a_por_off: assert property ((supplyBelowFall && !supplyAboveRise)[*6] |-> !softStartRun)
        else $error("running with supply low");
    a_setpoint_map: assert property ($stable(voltageCodeInputs)[*5] |-> setpointCode == spv(voltageCodeInputs))
        else $error("set-point does not match code");

    c_dem_entry: cover property ($rose(diodeEmulationMode));
    c_pg_release: cover property ($fell(powerGoodOe));
    c_fault_clamp: cover property (severeOvervoltage && lowSideGateDrive && !highSideGateDrive);
endmodule : bms_asserts

bind bms_mode_sequencer bms_asserts #(.START_DELAY_CYCLES(START_DELAY_CYCLES)) u_asserts (.*);

// [verification/bms_power_stage.sv]
// Behavioural power stage, output filter and modulator facing the sequencer
module bms_power_stage #(
    parameter int PERIOD = 16
)
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // Gate drives
    input  wire logic highSideGateDrive,
    input  wire logic lowSideGateDrive,
    // Bench controls
    input  wire logic lightLoad,
    input  wire logic ovCmd,
    // Modulator and sense
    output logic      pwmRequest,
    output logic      phaseNodePositive,
    output logic      outputInWindow,
    output logic      severeOvervoltage,
    output logic      outputBelowRelease
);
    timeunit 1ns;
    timeprecision 1ps;
    int   tick_q;
    int   rises_q;
    logic hsPrev_q;

    always_ff @(posedge mclk)
    begin
        hsPrev_q <= highSideGateDrive;
        tick_q   <= (srst || tick_q == PERIOD - 1) ? 0 : tick_q + 1;
        if (srst)
            rises_q <= 0;
        else if (highSideGateDrive && !hsPrev_q && rises_q < 3)
            rises_q <= rises_q + 1;
    end

    assign pwmRequest = (tick_q < 4);
    // output settles after a few pulses
    assign outputInWindow = (rises_q >= 3);
    assign phaseNodePositive = highSideGateDrive | lightLoad;
    // clamp discharges the output once released
    assign severeOvervoltage = ovCmd;
    assign outputBelowRelease = !ovCmd;
endmodule : bms_power_stage

// [verification/tb_top.sv]
// Self-checking bench of the buck mode sequencer
module tb_top import bms_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SD = 8;
    localparam int DEM = 5, SSR = 4, PGOE = 3, HS = 2, LS = 1;
    logic        mclk = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        supplyAboveRise = 1'h1, supplyBelowFall = 1'h0, converterEnablePin = 1'h1;
    logic        forcedDiodeEmulationSelect = 1'h0, audioFilterEnable = 1'h0;
    logic        lightLoad = 1'h0, ovCmd = 1'h0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [4:0]  voltageCodeInputs = 5'h00;
    logic        pready, pslverr, pwmRequest, phaseNodePositive, outputInWindow;
    logic        severeOvervoltage, outputBelowRelease, highSideGateDrive, lowSideGateDrive;
    logic        powerGoodOut, powerGoodOe, softStartRun, windowBoost, audioFilterActive;
    logic        diodeEmulationMode;
    logic [16:0] setpointCode;
    int          error_cnt = 0, check_count = 0, cyc = 0;
    // Open-drain pin with its pull-up
    wire logic   pgPin = powerGoodOe ? powerGoodOut : 1'h1;
    wire logic [5:0] obs = {diodeEmulationMode, softStartRun, powerGoodOe,
                            highSideGateDrive, lowSideGateDrive, windowBoost};

    bms_mode_sequencer #(.START_DELAY_CYCLES(SD)) DUT (.*);
    bms_power_stage PS (.*);

    always #10 mclk = ~mclk;

    task finish_test;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test();
        end
    end

    // ------
    // Shared tasks
    // ------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick

    task wfor(input int i, input logic v, input int lim);
        int n;
        n = 0;
        while (obs[i] !== v && n < lim)
        begin
            @(posedge mclk);
            n++;
        end
        chk(obs[i], v);
    endtask : wfor

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do
        begin
            @(posedge mclk);
        end
        while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task rst;
        supplyAboveRise <= 1'h1;
        supplyBelowFall <= 1'h0;
        converterEnablePin <= 1'h1;
        forcedDiodeEmulationSelect <= 1'h0;
        audioFilterEnable <= 1'h0;
        voltageCodeInputs <= 5'h00;
        lightLoad <= 1'h0;
        ovCmd <= 1'h0;
        srst <= 1'h1;
        tick(4);
        srst <= 1'h0;
    endtask : rst

    // ------
    // Scenarios
    // ------
    task t_regs;
        rst();
        apb(1'h0, ADDR_CTRL, 32'h0);
        chk(rd, 32'h1);
        apb(1'h0, 12'h0FC, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000);
        apb(1'h1, ADDR_SETPOINT, 32'h0);
        apb(1'h0, ADDR_SETPOINT, 32'h0);
        chk(rd, 32'h1F6EE);
        apb(1'h1, ADDR_CTRL, 32'h0);
        tick(SD + 8);
        chk(softStartRun, 1'h0);
        $display("test regs done");
    endtask : t_regs

    task t_por;
        rst();
        supplyAboveRise <= 1'h0;
        supplyBelowFall <= 1'h1;
        tick(20);
        chk({softStartRun, pgPin}, 2'h0);
        supplyBelowFall <= 1'h0;
        tick(20);
        chk(softStartRun, 1'h0);
        supplyAboveRise <= 1'h1;
        tick(SD + 2);
        chk(softStartRun, 1'h0);
        wfor(SSR, 1'h1, 10);
        supplyAboveRise <= 1'h0;
        tick(10);
        chk(softStartRun, 1'h1);
        supplyBelowFall <= 1'h1;
        tick(8);
        chk({softStartRun, pgPin}, 2'h0);
        $display("test por done");
    endtask : t_por

    task t_start;
        int n, pw, dm;
        logic pv;
        rst();
        forcedDiodeEmulationSelect <= 1'h1;
        lightLoad <= 1'h1;
        n = 0;
        pw = 0;
        dm = 0;
        pv = 1'h1;
        while (powerGoodOe !== 1'h0 && n < 600)
        begin
            @(posedge mclk);
            n++;
            pw += (outputInWindow && pwmRequest && !pv);
            dm += diodeEmulationMode;
            pv = pwmRequest;
        end
        chk(pw, 6);
        chk(dm, 0);
        chk(pgPin, 1'h1);
        $display("test start done");
    endtask : t_start

    task t_dem;
        int n, lr;
        logic lp;
        rst();
        voltageCodeInputs <= 5'h10;
        wfor(PGOE, 1'h0, 600);
        lightLoad <= 1'h1;
        n = 0;
        lr = 0;
        lp = 1'h1;
        while (diodeEmulationMode !== 1'h1 && n < 400)
        begin
            @(posedge mclk);
            n++;
            lr += (lowSideGateDrive && !lp);
            lp = lowSideGateDrive;
        end
        chk(lr inside {[8:9]}, 1'h1);
        tick(3);
        chk(windowBoost, 1'h1);
        n = 0;
        repeat (32)
        begin
            @(posedge mclk);
            n += (!highSideGateDrive && !lowSideGateDrive);
        end
        chk(n > 0, 1'h1);
        audioFilterEnable <= 1'h1;
        tick(6);
        chk({audioFilterActive, windowBoost}, 2'h2);
        audioFilterEnable <= 1'h0;
        lightLoad <= 1'h0;
        wfor(DEM, 1'h0, 40);
        tick(3);
        chk(windowBoost, 1'h0);
        $display("test emulation done");
    endtask : t_dem

    task t_fde;
        int n, m;
        rst();
        lightLoad <= 1'h1;
        wfor(PGOE, 1'h0, 600);
        n = 0;
        m = 0;
        repeat (200)
        begin
            @(posedge mclk);
            n += (highSideGateDrive === lowSideGateDrive);
            m += diodeEmulationMode;
        end
        chk(n, 0);
        chk(m, 0);
        forcedDiodeEmulationSelect <= 1'h1;
        wfor(DEM, 1'h1, 300);
        $display("test select done");
    endtask : t_fde

    task t_code;
        rst();
        for (int c = 0; c < 32; c++)
        begin
            voltageCodeInputs <= 5'(c);
            tick(5);
            chk(setpointCode, (c == 31) ? 32'h0A0F0 : 32'h1F6EE - c * 32'h00A0F);
        end
        $display("test code done");
    endtask : t_code

    task t_ov;
        rst();
        wfor(PGOE, 1'h0, 600);
        ovCmd <= 1'h1;
        tick(6);
        chk({highSideGateDrive, lowSideGateDrive, pgPin}, 3'h2);
        ovCmd <= 1'h0;
        tick(6);
        chk(lowSideGateDrive, 1'h0);
        converterEnablePin <= 1'h0;
        tick(8);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk(rd[2:0], 3'h5);
        supplyAboveRise <= 1'h0;
        supplyBelowFall <= 1'h1;
        tick(8);
        apb(1'h0, ADDR_STATUS, 32'h0);
        chk(rd[2:0], 3'h0);
        $display("test fault done");
    endtask : t_ov

    task t_enable;
        rst();
        wfor(PGOE, 1'h0, 600);
        converterEnablePin <= 1'h0;
        tick(6);
        chk({softStartRun, highSideGateDrive, pgPin}, 3'h0);
        $display("test enable done");
    endtask : t_enable

    initial
    begin
        t_regs();
        t_por();
        t_start();
        t_dem();
        t_fde();
        t_code();
        t_ov();
        t_enable();
        finish_test();
    end
endmodule : tb_top
